// ==== lcc_defines.svh ====
// Register offsets, field positions and reset values of the channel configuration bank
//Contract
//- Second color scale byte drives color scale DAC.
//- Bias bit 4 selects accurate reference, resets one.
//- Bias bits 3:0 set bias, default eight.
//- Threshold scale bits 7:2, reset 0xfc.
//- Upper serial byte gives pixel bits 9:2.
//- Lower serial bits 7:6 give pixel bits 1:0.
//- Control bit 7 enables third output.
//- Control bit 5 reduces bias on zero pixel.
//- Control bit 4 gates third color DAC.
//- Threshold control bit 7 enables threshold DAC.
//- Bit 4 lets low-power signal sleep threshold DAC.
//- Bit 3 makes threshold DAC follow color sleep.
//- Bits 2:1 decode return-to-zero handling.
//- Bit 0 ties bias reduction to threshold current.
//- Threshold code byte drives threshold current DAC.
`ifndef LCC_DEFINES_SVH
`define LCC_DEFINES_SVH
`define LCC_OFS_CH2_COLOR_SCALE 8'h23
`define LCC_OFS_CH2_BIAS_REFERENCE 8'h24
`define LCC_OFS_CH2_THRESHOLD_SCALE 8'h26
`define LCC_OFS_CH2_SERIAL_PIXEL_UPPER 8'h2e
`define LCC_OFS_CH2_SERIAL_PIXEL_LOWER 8'h2f
`define LCC_OFS_CH3_CONTROL 8'h30
`define LCC_OFS_CH3_THRESHOLD_CONTROL 8'h31
`define LCC_OFS_CH3_THRESHOLD_CODE 8'h32
`define LCC_OFS_SERIAL_ENABLE 8'h40
`define LCC_RST_CH2_COLOR_SCALE 8'h00
`define LCC_RST_CH2_BIAS_REFERENCE 8'h18
`define LCC_RST_CH2_THRESHOLD_SCALE 8'hfc
`define LCC_RST_CH2_SERIAL_PIXEL_UPPER 8'h00
`define LCC_RST_CH2_SERIAL_PIXEL_LOWER 8'h00
`define LCC_RST_CH3_CONTROL 8'hb0
`define LCC_RST_CH3_THRESHOLD_CONTROL 8'h91
`define LCC_RST_CH3_THRESHOLD_CODE 8'h00
`define LCC_MASK_CH2_BIAS_REFERENCE 8'h1f
`define LCC_MASK_CH2_THRESHOLD_SCALE 8'hfc
`define LCC_MASK_CH2_SERIAL_PIXEL_LOWER 8'hc0
`define LCC_MASK_CH3_CONTROL 8'hb0
`define LCC_MASK_CH3_THRESHOLD_CONTROL 8'h9f
`define LCC_BIT_REF_ACCURATE 4
`define LCC_BIT_CH3_OUT_EN 7
`define LCC_BIT_CH3_AUTO_SLEEP 5
`define LCC_BIT_CH3_COLOR_EN 4
`define LCC_BIT_THR_EN 7
`define LCC_BIT_THR_LOWP 4
`define LCC_BIT_THR_FOLLOW 3
`define LCC_BIT_RTZ_HI 2
`define LCC_BIT_RTZ_LO 1
`define LCC_BIT_THR_BIAS_RED 0
`endif

// ==== lcc_pkg.sv ====
// Types of the channel configuration bank
package lcc_pkg;
	typedef logic [7:0] lcc_byte_t;
	typedef logic [9:0] lcc_pixel_t;
	typedef logic [31:0] lcc_word_t;
endpackage : lcc_pkg

// ==== lcc_regs.sv ====
// APB register bank steering the second and third laser output channels
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
`include "lcc_defines.svh"
module lcc_regs (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire lcc_pkg::lcc_word_t pwdata,
	input wire logic [3:0] pstrb,
	output logic pready,
	output lcc_pkg::lcc_word_t prdata,
	output logic pslverr,
	input wire logic low_power_in,
	input wire logic return_to_zero_in,
	input wire logic ch3_color_sleep_in,
	input wire logic ch3_pixel_zero_in,
	output lcc_pkg::lcc_byte_t ch2_color_scale_code,
	output logic ch2_ref_accurate,
	output logic [3:0] ch2_bias_code,
	output logic [5:0] ch2_threshold_scale_code,
	output logic ch2_serial_enable,
	output lcc_pkg::lcc_pixel_t ch2_serial_pixel,
	output logic ch3_output_enable,
	output logic ch3_color_dac_enable,
	output logic ch3_color_bias_reduce,
	output logic ch3_threshold_sleep,
	output logic ch3_threshold_zero,
	output logic ch3_bias_follow_threshold,
	output lcc_pkg::lcc_byte_t ch3_threshold_code_field
);
	import lcc_pkg::*;

	lcc_byte_t color_scale_ff;
	lcc_byte_t bias_ref_ff;
	lcc_byte_t thr_scale_ff;
	lcc_byte_t pix_upper_ff;
	lcc_byte_t pix_lower_ff;
	lcc_byte_t ch3_ctrl_ff;
	lcc_byte_t thr_ctrl_ff;
	lcc_byte_t thr_code_ff;
	logic serial_en_ff;
	logic lowp_meta_ff;
	logic lowp_sync_ff;
	logic rtz_meta_ff;
	logic rtz_sync_ff;
	logic [7:0] word_addr;
	logic addr_ok;
	logic wr_go;
	lcc_word_t nxt_prdata;
	lcc_word_t prdata_ff;
	logic nxt_thr_sleep;

	assign word_addr = paddr[9:2];
	// Zero-wait slave: byte addresses are four times the printed offsets
	assign pready = 1'b1;
	always_comb
	begin
		case (word_addr)
			`LCC_OFS_CH2_COLOR_SCALE, `LCC_OFS_CH2_BIAS_REFERENCE,
			`LCC_OFS_CH2_THRESHOLD_SCALE, `LCC_OFS_CH2_SERIAL_PIXEL_UPPER,
			`LCC_OFS_CH2_SERIAL_PIXEL_LOWER, `LCC_OFS_CH3_CONTROL,
			`LCC_OFS_CH3_THRESHOLD_CONTROL, `LCC_OFS_CH3_THRESHOLD_CODE,
			`LCC_OFS_SERIAL_ENABLE: addr_ok = (paddr[31:10] == 22'h0) && (paddr[1:0] == 2'h0);
			default: addr_ok = 1'b0;
		endcase
	end
	assign pslverr = psel & penable & ~addr_ok;
	// Only lane 0 carries register data, so its strobe gates every write
	assign wr_go = psel & penable & pwrite & addr_ok & pstrb[0];

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			color_scale_ff <= `LCC_RST_CH2_COLOR_SCALE;
			bias_ref_ff <= `LCC_RST_CH2_BIAS_REFERENCE;
			thr_scale_ff <= `LCC_RST_CH2_THRESHOLD_SCALE;
			pix_upper_ff <= `LCC_RST_CH2_SERIAL_PIXEL_UPPER;
			pix_lower_ff <= `LCC_RST_CH2_SERIAL_PIXEL_LOWER;
			ch3_ctrl_ff <= `LCC_RST_CH3_CONTROL;
			thr_ctrl_ff <= `LCC_RST_CH3_THRESHOLD_CONTROL;
			thr_code_ff <= `LCC_RST_CH3_THRESHOLD_CODE;
			serial_en_ff <= 1'b0;
		end
		else if (wr_go)
		begin
			case (word_addr)
				`LCC_OFS_CH2_COLOR_SCALE: color_scale_ff <= pwdata[7:0];
				`LCC_OFS_CH2_BIAS_REFERENCE:
					bias_ref_ff <= pwdata[7:0] & `LCC_MASK_CH2_BIAS_REFERENCE;
				`LCC_OFS_CH2_THRESHOLD_SCALE:
					thr_scale_ff <= pwdata[7:0] & `LCC_MASK_CH2_THRESHOLD_SCALE;
				`LCC_OFS_CH2_SERIAL_PIXEL_UPPER: pix_upper_ff <= pwdata[7:0];
				`LCC_OFS_CH2_SERIAL_PIXEL_LOWER:
					pix_lower_ff <= pwdata[7:0] & `LCC_MASK_CH2_SERIAL_PIXEL_LOWER;
				`LCC_OFS_CH3_CONTROL: ch3_ctrl_ff <= pwdata[7:0] & `LCC_MASK_CH3_CONTROL;
				`LCC_OFS_CH3_THRESHOLD_CONTROL:
					thr_ctrl_ff <= pwdata[7:0] & `LCC_MASK_CH3_THRESHOLD_CONTROL;
				`LCC_OFS_CH3_THRESHOLD_CODE: thr_code_ff <= pwdata[7:0];
				`LCC_OFS_SERIAL_ENABLE: serial_en_ff <= pwdata[0];
				default: serial_en_ff <= serial_en_ff;
			endcase
		end
	end

	always_comb
	begin
		case (word_addr)
			`LCC_OFS_CH2_COLOR_SCALE: nxt_prdata = {24'h0, color_scale_ff};
			`LCC_OFS_CH2_BIAS_REFERENCE: nxt_prdata = {24'h0, bias_ref_ff};
			`LCC_OFS_CH2_THRESHOLD_SCALE: nxt_prdata = {24'h0, thr_scale_ff};
			`LCC_OFS_CH2_SERIAL_PIXEL_UPPER: nxt_prdata = {24'h0, pix_upper_ff};
			`LCC_OFS_CH2_SERIAL_PIXEL_LOWER: nxt_prdata = {24'h0, pix_lower_ff};
			`LCC_OFS_CH3_CONTROL: nxt_prdata = {24'h0, ch3_ctrl_ff};
			`LCC_OFS_CH3_THRESHOLD_CONTROL: nxt_prdata = {24'h0, thr_ctrl_ff};
			`LCC_OFS_CH3_THRESHOLD_CODE: nxt_prdata = {24'h0, thr_code_ff};
			`LCC_OFS_SERIAL_ENABLE: nxt_prdata = {31'h0, serial_en_ff};
			default: nxt_prdata = 32'h0;
		endcase
		if (!addr_ok)
		begin
			nxt_prdata = 32'h0;
		end
	end
	// Read data is caught in the setup cycle; no register changes before the access edge
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			prdata_ff <= 32'h0;
		end
		else if (psel && !penable)
		begin
			prdata_ff <= nxt_prdata;
		end
	end
	assign prdata = prdata_ff;

	// The low-power and return-to-zero pins cross in from outside through two flops; color sleep and pixel zero go in unsynchronized
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			lowp_meta_ff <= 1'b0;
			lowp_sync_ff <= 1'b0;
			rtz_meta_ff <= 1'b0;
			rtz_sync_ff <= 1'b0;
		end
		else
		begin
			lowp_meta_ff <= low_power_in;
			lowp_sync_ff <= lowp_meta_ff;
			rtz_meta_ff <= return_to_zero_in;
			rtz_sync_ff <= rtz_meta_ff;
		end
	end

	assign ch2_color_scale_code = color_scale_ff;
	assign ch2_ref_accurate = bias_ref_ff[`LCC_BIT_REF_ACCURATE];
	// Zero bias is only sane in constant-current mode; software owns that choice
	assign ch2_bias_code = bias_ref_ff[3:0];
	assign ch2_threshold_scale_code = thr_scale_ff[7:2];
	assign ch2_serial_enable = serial_en_ff;
	// Pixel reads zero while serial entry is off so the parallel path wins
	assign ch2_serial_pixel = serial_en_ff ? {pix_upper_ff, pix_lower_ff[7:6]} : 10'h0;
	assign ch3_output_enable = ch3_ctrl_ff[`LCC_BIT_CH3_OUT_EN];
	assign ch3_color_bias_reduce = ch3_ctrl_ff[`LCC_BIT_CH3_AUTO_SLEEP] & ch3_pixel_zero_in;
	assign ch3_color_dac_enable = ch3_ctrl_ff[`LCC_BIT_CH3_COLOR_EN];

	always_comb
	begin
		nxt_thr_sleep = ~thr_ctrl_ff[`LCC_BIT_THR_EN];
		if (thr_ctrl_ff[`LCC_BIT_THR_LOWP] && lowp_sync_ff)
		begin
			nxt_thr_sleep = 1'b1;
		end
		if (thr_ctrl_ff[`LCC_BIT_THR_FOLLOW] && ch3_color_sleep_in)
		begin
			nxt_thr_sleep = 1'b1;
		end
		if (thr_ctrl_ff[`LCC_BIT_RTZ_HI] && thr_ctrl_ff[`LCC_BIT_RTZ_LO] && rtz_sync_ff)
		begin
			nxt_thr_sleep = 1'b1;
		end
	end
	assign ch3_threshold_sleep = nxt_thr_sleep;
	assign ch3_threshold_zero = thr_ctrl_ff[`LCC_BIT_RTZ_HI] & rtz_sync_ff;
	assign ch3_bias_follow_threshold = thr_ctrl_ff[`LCC_BIT_THR_BIAS_RED];
	assign ch3_threshold_code_field = thr_code_ff;
endmodule : lcc_regs

// ==== lcc_regs_assertions.sv ====
// Port checker of the channel configuration register bank
`timescale 1ns/1ps
module lcc_regs_assertions (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire lcc_pkg::lcc_word_t pwdata,
	input wire logic [3:0] pstrb,
	input wire lcc_pkg::lcc_word_t prdata,
	input wire logic pslverr,
	input wire logic ch3_pixel_zero_in,
	input wire logic ch2_ref_accurate,
	input wire logic [3:0] ch2_bias_code,
	input wire logic [5:0] ch2_threshold_scale_code,
	input wire logic ch2_serial_enable,
	input wire lcc_pkg::lcc_pixel_t ch2_serial_pixel,
	input wire logic ch3_color_bias_reduce,
	input wire logic ch3_threshold_sleep,
	input wire logic ch3_threshold_zero
);
	import lcc_pkg::*;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	logic wr, rd;
	assign wr = psel && penable && pwrite && pstrb[0];
	assign rd = psel && penable && !pwrite;
	chk_bias_write: assert property (wr && paddr == 32'h90
		|=> {ch2_ref_accurate, ch2_bias_code} == $past(pwdata[4:0])) else $error("bias lost");
	chk_scale_write: assert property (wr && paddr == 32'h98
		|=> ch2_threshold_scale_code == $past(pwdata[7:2])) else $error("scale lost");
	chk_pixel_upper: assert property (rd && paddr == 32'hb8 && ch2_serial_enable
		|-> prdata[7:0] == ch2_serial_pixel[9:2]) else $error("pixel upper wrong");
	chk_pixel_lower: assert property (rd && paddr == 32'hbc && ch2_serial_enable
		|-> prdata == {ch2_serial_pixel[1:0], 6'h00}) else $error("pixel lower wrong");
	chk_bias_reduce: assert property (rd && paddr == 32'hc0
		|-> ch3_color_bias_reduce == (prdata[5] && ch3_pixel_zero_in)) else $error("reduce wrong");
	chk_thr_disable: assert property (rd && paddr == 32'hc4 && !prdata[7]
		|-> ch3_threshold_sleep) else $error("disabled dac awake");
	chk_rtz_ignore: assert property (rd && paddr == 32'hc4 && !prdata[2]
		|-> !ch3_threshold_zero) else $error("rtz not ignored");
	chk_bad_addr: assert property (psel && penable && paddr[1:0] != 2'h0
		|-> pslverr && prdata == 32'h0) else $error("bad address accepted");
	cover property (wr && paddr == 32'hc4);
	cover property (rd && pslverr);
	cover property (ch3_threshold_sleep && ch3_threshold_zero);
endmodule : lcc_regs_assertions

// ==== test_lcc_regs.sv ====
// Self-checking bench of the channel configuration register bank
`timescale 1ns/1ps
module test_lcc_regs;
	import lcc_pkg::*;
	logic sys_clk = 1'b0;
	logic rst, psel, penable, pwrite, pready, pslverr, e, low_power_in, return_to_zero_in;
	logic ch3_color_sleep_in, ch3_pixel_zero_in, ch2_ref_accurate, ch2_serial_enable;
	logic ch3_output_enable, ch3_color_dac_enable, ch3_color_bias_reduce, ch3_threshold_sleep;
	logic ch3_threshold_zero, ch3_bias_follow_threshold;
	logic [3:0] pstrb, ch2_bias_code;
	logic [5:0] ch2_threshold_scale_code;
	logic [31:0] paddr;
	lcc_word_t pwdata, prdata, r;
	lcc_byte_t ch2_color_scale_code, ch3_threshold_code_field;
	lcc_pixel_t ch2_serial_pixel;
	int n_tests = 0;
	int n_mismatch = 0;
	int cyc = 0;
	lcc_byte_t ofs [8] = '{8'h23, 8'h24, 8'h26, 8'h2e, 8'h2f, 8'h30, 8'h31, 8'h32};
	lcc_byte_t rstv [8] = '{8'h00, 8'h18, 8'hfc, 8'h00, 8'h00, 8'hb0, 8'h91, 8'h00};
	lcc_byte_t msk [8] = '{8'hff, 8'h1f, 8'hfc, 8'hff, 8'hc0, 8'hb0, 8'h9f, 8'hff};
	lcc_regs lcc_regs_inst (.*);
	initial forever #20 sys_clk = ~sys_clk;
	task automatic finish_test;
		$display("tests %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : finish_test
	// Bench hang guard, well above the few hundred cycles the tests need
	always @(posedge sys_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 4000)
		begin
			n_mismatch++;
			finish_test;
		end
	end
	task automatic cmp(input lcc_word_t got, input lcc_word_t exp);
		n_tests++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp
	task automatic apb(input logic [31:0] a, input logic w, input lcc_word_t d);
		@(posedge sys_clk);
		{psel, paddr, pwrite, pwdata} <= {1'b1, a, w, d};
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		while (pready !== 1'b1)
			@(posedge sys_clk);
		{r, e} = {prdata, pslverr};
		{psel, penable} <= 2'b00;
	endtask : apb
	task automatic rd(input lcc_byte_t o, input lcc_word_t x);
		apb({o, 2'h0}, 1'b0, 32'h0);
		cmp(r, x);
	endtask : rd
	task automatic wr(input lcc_byte_t o, input lcc_byte_t d);
		apb({o, 2'h0}, 1'b1, {24'h0, d});
		#1;
	endtask : wr
	task automatic settle;
		repeat (3) @(posedge sys_clk);
		#1;
	endtask : settle
	task automatic t_map;
		#1;
		cmp({ch2_ref_accurate, ch2_bias_code, ch2_threshold_scale_code}, 11'h63f);
		cmp({ch3_output_enable, ch3_color_dac_enable, ch3_bias_follow_threshold}, 3'h7);
		for (int i = 0; i < 8; i++)
			rd(ofs[i], rstv[i]);
		wr(8'h40, 8'h01);
		for (int i = 0; i < 8; i++)
		begin
			wr(ofs[i], 8'hff);
			rd(ofs[i], msk[i]);
			wr(ofs[i], 8'h00);
			rd(ofs[i], 32'h0);
		end
		cmp({ch3_output_enable, ch3_color_dac_enable, ch3_threshold_sleep}, 3'h1);
		cmp(ch3_bias_follow_threshold, 1'b0);
		pstrb <= 4'h0;
		wr(8'h23, 8'h77);
		pstrb <= 4'hf;
		apb(32'h8d, 1'b1, 32'hff);
		cmp(e, 1'b1);
		rd(8'h23, 32'h0);
	endtask : t_map
	task automatic t_dac;
		wr(8'h23, 8'h5a);
		wr(8'h32, 8'hc3);
		wr(8'h2e, 8'ha5);
		wr(8'h2f, 8'hff);
		cmp({ch2_color_scale_code, ch3_threshold_code_field}, 16'h5ac3);
		cmp(ch2_serial_pixel, 10'h297);
		wr(8'h40, 8'h00);
		cmp({ch2_serial_enable, ch2_serial_pixel}, 11'h0);
		wr(8'h40, 8'h01);
		cmp({ch2_serial_enable, ch2_serial_pixel}, 11'h697);
	endtask : t_dac
	task automatic t_ch3;
		wr(8'h30, 8'h20);
		ch3_pixel_zero_in <= 1'b1;
		settle;
		cmp(ch3_color_bias_reduce, 1'b1);
		ch3_pixel_zero_in <= 1'b0;
		settle;
		cmp(ch3_color_bias_reduce, 1'b0);
		return_to_zero_in <= 1'b1;
		for (int k = 0; k < 4; k++)
		begin
			wr(8'h31, 8'h80 | 8'(k << 1));
			settle;
			cmp({ch3_threshold_sleep, ch3_threshold_zero}, {k == 3, k[1]});
		end
		low_power_in <= 1'b1;
		wr(8'h31, 8'h90);
		settle;
		cmp(ch3_threshold_sleep, 1'b1);
		ch3_color_sleep_in <= 1'b1;
		wr(8'h31, 8'h88);
		cmp(ch3_threshold_sleep, 1'b1);
		wr(8'h31, 8'h80);
		cmp(ch3_threshold_sleep, 1'b0);
	endtask : t_ch3
	initial
	begin
		{rst, psel, penable, pwrite, paddr, pwdata, pstrb} = {3'h4, 65'h0, 4'hf};
		{low_power_in, return_to_zero_in, ch3_color_sleep_in, ch3_pixel_zero_in} = 4'h0;
		repeat (6) @(posedge sys_clk);
		rst <= 1'b0;
		t_map;
		t_dac;
		t_ch3;
		finish_test;
	end
endmodule : test_lcc_regs
bind lcc_regs lcc_regs_assertions lcc_regs_assertions_inst (.*);
